// ---- design/pcp_cfg.svh ----
`ifndef PCP_CFG_SVH
`define PCP_CFG_SVH

// Program counter vectors and program memory limits.
`define PCP_RESET_VEC     16'h0000
`define PCP_IRQ_VEC       16'h0004
`define PCP_OPT_ADDR      16'h001f
`define PCP_PM_LAST       16'h0fff
`define PCP_PM_AW         12

// Option word layout and unprogrammed value.
`define PCP_OPT_BLANK     14'h3fff
`define PCP_OPT_EN_BIT    8
`define PCP_OPT_LVL_HI    7
`define PCP_OPT_LVL_LO    4
`define PCP_OPT_OSC_HI    3
`define PCP_OPT_OSC_LO    1
`define PCP_LVL_2V6       4'hc
`define PCP_LVL_3V0       4'h7
`define PCP_LVL_4V0       4'h4

// Branch field width and page bits taken from the high latch.
`define PCP_BR_W          11
`define PCP_PAGE_HI       7
`define PCP_PAGE_LO       3

// Stack geometry.
`define PCP_STK_DEPTH     8
`define PCP_STK_PW        3

// Register offsets on the bus (byte addresses).
`define PCP_OFS_PC_LOW    8'h00
`define PCP_OFS_HI_LATCH  8'h04
`define PCP_OFS_OPT_RAW   8'h08
`define PCP_OFS_OPT_DEC   8'h0c
`define PCP_OFS_STATUS    8'h10

// Reset values.
`define PCP_HI_LATCH_RST  8'h00

`endif

// ---- design/pcp_pkg.sv ----
package pcp_pkg;

  // Start-up sequencer states.
  typedef enum logic [1:0] {
    PCP_BOOT_REQ = 2'b00,
    PCP_BOOT_CAP = 2'b01,
    PCP_RUN      = 2'b10
  } pcp_state_e;

  // Decoded low-voltage reset threshold.
  typedef enum logic [1:0] {
    PCP_LVL_NONE = 2'b00,
    PCP_LVL_2V6  = 2'b01,
    PCP_LVL_3V0  = 2'b10,
    PCP_LVL_4V0  = 2'b11
  } pcp_level_e;

  // Decoded oscillator choice.
  typedef enum logic [2:0] {
    PCP_OSC_EXT_RC  = 3'b000,
    PCP_OSC_RC_4M   = 3'b001,
    PCP_OSC_RC_2M   = 3'b010,
    PCP_OSC_RC_1M   = 3'b011,
    PCP_OSC_RC_8M   = 3'b100,
    PCP_OSC_XTAL    = 3'b101,
    PCP_OSC_INVALID = 3'b111
  } pcp_osc_e;

endpackage : pcp_pkg

// ---- design/pcp_stack_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcp_cfg.svh"

// Eight-entry circular return stack; the top entry comes out of a register.
module pcp_stack_mem (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Push and pop requests.
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [15:0] push_data,
  // Registered top of stack.
  output logic      [15:0] top_data
);

  logic [15:0]                 mem [`PCP_STK_DEPTH];
  logic [`PCP_STK_PW-1:0]      ptr_reg;
  logic [`PCP_STK_PW-1:0]      ptr_m2;

  assign ptr_m2 = ptr_reg - `PCP_STK_PW'(2);

  // Entries are written at the pointer; wrapping overwrites the oldest one.
  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem[ptr_reg] <= push_data;
    end
  end

  // The pointer wraps freely, with no overflow or underflow flag.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= '0;
    end else if (ce && push) begin
      ptr_reg <= ptr_reg + `PCP_STK_PW'(1);
    end else if (ce && pop) begin
      ptr_reg <= ptr_reg - `PCP_STK_PW'(1);
    end
  end

  // The top register follows pushes and pops so a pop needs no read latency.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      top_data <= 16'h0000;
    end else if (ce && push) begin
      top_data <= push_data;
    end else if (ce && pop) begin
      top_data <= mem[ptr_m2];
    end
  end

endmodule : pcp_stack_mem
`default_nettype wire

// ---- design/pcp_program_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcp_cfg.svh"

// Contract
// - Sixteen-bit program counter spans 64k words of 14 bits.
// - Reset starts fetching at 0000H; an interrupt branches to 0004H.
// - Start-up option word is read from word 001FH and applied.
// - Unprogrammed option 3FFFH means low-voltage reset off, crystal oscillator.
// - Implemented program memory is 4k words, 0000H to 0FFFH.
// - Option bit 8 enables low-voltage reset when 0, disables when 1.
// - Level field codes 1100, 0111, 0100 select 2.6, 3.0, 4.0 V.
// - Oscillator field: 000 ext RC, 001-100 int RC, 111 crystal.
// - Option decoder ignores bit 0 and bits 9 to 13.
// - Counter bits 7 to 0 live in a readable, writable low byte.
// - Counter upper byte is not directly accessible; loaded via high latch.
// - Any reset clears the counter upper byte.
// - Writing the low byte copies the whole high latch into upper byte.
// - CALL and GOTO take 11 bits from instruction, 5 from latch 7:3.
// - Returns reload all 16 counter bits from stack, latch unused.
// - CALL and interrupt branch push the program counter onto the stack.
// - Stack holds eight 16-bit entries circularly; ninth push overwrites first.
module pcp_program_counter
  import pcp_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  // APB slave.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Instruction decoder requests.
  input  wire logic                   fetch_step,
  input  wire logic                   call_req,
  input  wire logic                   goto_req,
  input  wire logic                   return_req,
  input  wire logic                   irq_take,
  input  wire logic [10:0]            branch_target,
  // Program memory port.
  output logic      [`PCP_PM_AW-1:0]  pm_addr,
  input  wire logic [13:0]            pm_rdata,
  // Fetch status to the core.
  output logic      [15:0]            fetch_pc,
  output logic                        core_run,
  output logic                        pc_out_of_range,
  // Decoded start-up options.
  output logic                        low_voltage_reset_on,
  output pcp_level_e                  lvr_level,
  output pcp_osc_e                    osc_select
);

  pcp_state_e   state_reg;
  pcp_state_e   state_next;
  logic [15:0]  pc_reg;
  logic [15:0]  pc_next;
  logic [7:0]   pc_high_latch_reg;
  logic [13:0]  option_reg;
  logic [15:0]  stack_top;
  logic         push_en;
  logic         pop_en;
  logic         apb_setup;
  logic         apb_done;
  logic         wr_pc_low;
  logic         wr_hi_latch;
  logic         brownout_reset_enable;
  logic [3:0]   brownout_level_select;
  logic [2:0]   osc_field;
  logic         level_invalid;
  pcp_level_e   level_dec;
  pcp_osc_e     osc_dec;
  logic [31:0]  rd_mux;
  logic         rd_hit;
  logic         run_now;
  logic         apb_access;
  logic [7:0]   wr_byte;
  logic [7:0]   pc_low_byte;
  logic         ld_irq;
  logic         ld_ret;
  logic         ld_branch;
  logic         ld_wr;
  logic         ld_step;
  logic [6:0]   opt_dec_word;

  // Bus phase decode and the write data byte that both writable registers use.
  assign apb_setup   = psel && !penable;
  assign apb_access  = psel && penable;
  assign apb_done    = apb_access && pready;
  assign wr_byte     = pwdata[7:0];

  // Write strobes; a write takes effect at the edge that completes access.
  assign wr_pc_low   = apb_done && pwrite && (paddr == `PCP_OFS_PC_LOW);
  assign wr_hi_latch = apb_done && pwrite && (paddr == `PCP_OFS_HI_LATCH);

  // Start-up sequencer: one request at the option address, then capture.
  always_comb begin
    case (state_reg)
      PCP_BOOT_REQ: state_next = PCP_BOOT_CAP;
      PCP_BOOT_CAP: state_next = PCP_RUN;
      PCP_RUN:      state_next = PCP_RUN;
      default:      state_next = PCP_BOOT_REQ;
    endcase
  end

  // Sequencer state register; it holds while the clock enable is low.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PCP_BOOT_REQ;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // The counter only takes core requests once the option word is in.
  assign run_now = (state_reg == PCP_RUN);

  // Stack traffic: push on a CALL or an interrupt branch, pop on a return without a simultaneous interrupt branch.
  assign push_en = run_now && (irq_take || call_req);
  assign pop_en  = ld_ret;

  // Load source selects in priority order; at most one of them is set.
  assign ld_irq    = run_now && irq_take;
  assign ld_ret    = run_now && !irq_take && return_req;
  assign ld_branch = run_now && !irq_take && !return_req && (call_req || goto_req);
  assign ld_wr     = run_now && !irq_take && !return_req && !call_req && !goto_req
                     && wr_pc_low;
  assign ld_step   = run_now && !irq_take && !return_req && !call_req && !goto_req
                     && !wr_pc_low && fetch_step;

  // Next counter value; interrupt vectoring has the highest priority.
  always_comb begin
    pc_next = pc_reg;
    if (!run_now) begin
      pc_next = `PCP_RESET_VEC;
    end else if (ld_irq) begin
      pc_next = `PCP_IRQ_VEC;
    end else if (ld_ret) begin
      pc_next = stack_top;
    end else if (ld_branch) begin
      pc_next = {pc_high_latch_reg[`PCP_PAGE_HI:`PCP_PAGE_LO], branch_target};
    end else if (ld_wr) begin
      pc_next = {pc_high_latch_reg, wr_byte};
    end else if (ld_step) begin
      pc_next = pc_reg + 16'h0001;
    end
  end

  // The full sixteen-bit counter; reset clears both bytes.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= `PCP_RESET_VEC;
    end else if (ce) begin
      pc_reg <= pc_next;
    end
  end

  // The high latch is only written by software, never by push or pop.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_high_latch_reg <= `PCP_HI_LATCH_RST;
    end else if (ce && wr_hi_latch) begin
      pc_high_latch_reg <= wr_byte;
    end
  end

  // Program memory address: the option word during boot, else the counter.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pm_addr <= `PCP_PM_AW'(`PCP_OPT_ADDR);
    end else if (ce) begin
      if (state_next == PCP_RUN) begin
        pm_addr <= pc_next[`PCP_PM_AW-1:0];
      end else begin
        pm_addr <= `PCP_PM_AW'(`PCP_OPT_ADDR);
      end
    end
  end

  // Fetch address output mirrors the next counter value.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_pc <= `PCP_RESET_VEC;
    end else if (ce) begin
      fetch_pc <= pc_next;
    end
  end

  // Run flag; high from the cycle in which normal fetching begins.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_run <= 1'b0;
    end else if (ce) begin
      core_run <= (state_next == PCP_RUN);
    end
  end

  // Range flag for counter values beyond the implemented memory.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_out_of_range <= 1'b0;
    end else if (ce) begin
      pc_out_of_range <= (pc_next > `PCP_PM_LAST);
    end
  end

  // Option word capture; the blank value stands until the read returns.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      option_reg <= `PCP_OPT_BLANK;
    end else if (ce && (state_reg == PCP_BOOT_CAP)) begin
      option_reg <= pm_rdata;
    end
  end

  // Field extraction; bit 0 and bits 9 to 13 are never looked at.
  assign brownout_reset_enable = !option_reg[`PCP_OPT_EN_BIT];
  assign brownout_level_select = option_reg[`PCP_OPT_LVL_HI:`PCP_OPT_LVL_LO];
  assign osc_field             = option_reg[`PCP_OPT_OSC_HI:`PCP_OPT_OSC_LO];

  // Threshold decode; an undefined code is flagged, while the reset is enabled, rather than guessed.
  always_comb begin
    level_invalid = 1'b0;
    case (brownout_level_select)
      `PCP_LVL_2V6: level_dec = PCP_LVL_2V6;
      `PCP_LVL_3V0: level_dec = PCP_LVL_3V0;
      `PCP_LVL_4V0: level_dec = PCP_LVL_4V0;
      default: begin
        level_dec     = PCP_LVL_NONE;
        level_invalid = brownout_reset_enable;
      end
    endcase
  end

  // Oscillator decode; codes 101 and 110 are undefined.
  always_comb begin
    case (osc_field)
      3'h0:    osc_dec = PCP_OSC_EXT_RC;
      3'h1:    osc_dec = PCP_OSC_RC_4M;
      3'h2:    osc_dec = PCP_OSC_RC_2M;
      3'h3:    osc_dec = PCP_OSC_RC_1M;
      3'h4:    osc_dec = PCP_OSC_RC_8M;
      3'h7:    osc_dec = PCP_OSC_XTAL;
      default: osc_dec = PCP_OSC_INVALID;
    endcase
  end

  // Low-voltage reset enable; it holds the blank-word meaning at reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_voltage_reset_on <= 1'b0;
    end else if (ce) begin
      low_voltage_reset_on <= brownout_reset_enable;
    end
  end

  // Threshold output; forced to none while the reset is disabled.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lvr_level <= PCP_LVL_NONE;
    end else if (ce) begin
      lvr_level <= brownout_reset_enable ? level_dec : PCP_LVL_NONE;
    end
  end

  // Oscillator choice; the blank word selects the crystal.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_select <= PCP_OSC_XTAL;
    end else if (ce) begin
      osc_select <= osc_dec;
    end
  end

  // Software views of the low counter byte and of the decoded option word.
  assign pc_low_byte  = pc_reg[7:0];
  assign opt_dec_word = {level_invalid, osc_dec, level_dec, brownout_reset_enable};

  // Read mux; the counter upper byte has no read path at all.
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `PCP_OFS_PC_LOW:   rd_mux[7:0]  = pc_low_byte;
      `PCP_OFS_HI_LATCH: rd_mux[7:0]  = pc_high_latch_reg;
      `PCP_OFS_OPT_RAW:  rd_mux[13:0] = option_reg;
      `PCP_OFS_OPT_DEC:  rd_mux[6:0]  = opt_dec_word;
      `PCP_OFS_STATUS:   rd_mux[1:0]  = {pc_out_of_range, core_run};
      default:           rd_hit       = 1'b0;
    endcase
  end

  // One wait-free access phase: ready rises in the cycle after setup.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= apb_setup;
    end
  end

  // Error flag for an unmapped address, given together with ready.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else if (ce) begin
      pslverr <= apb_setup && !rd_hit;
    end
  end

  // Read data are taken from the mux at the setup edge of a read and then stand.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (ce && apb_setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Return stack with a registered top entry.
  pcp_stack_mem u_stack (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .ce        (ce),
    .push      (push_en),
    .pop       (pop_en),
    .push_data (pc_reg),
    .top_data  (stack_top)
  );

endmodule : pcp_program_counter
`default_nettype wire

// ---- sim/pcp_program_counter_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcp_cfg.svh"

// Watches counter loads, fetch address and bus handshake of the paging block.
module pcp_program_counter_asserts (
  // Clock, reset and enable.
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic                  ce,
  // Bus.
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Core.
  input wire logic                  fetch_step,
  input wire logic                  call_req,
  input wire logic                  goto_req,
  input wire logic                  return_req,
  input wire logic                  irq_take,
  input wire logic [10:0]           branch_target,
  input wire logic [`PCP_PM_AW-1:0] pm_addr,
  input wire logic [15:0]           fetch_pc,
  input wire logic                  core_run,
  input wire logic                  pc_out_of_range
);
  logic ld;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Any load source that overrides the plain step.
  assign ld = irq_take | return_req | call_req | goto_req | (psel & penable & pwrite);

  irq_vector_a: assert property (core_run && ce && irq_take |=> fetch_pc == 16'h0004)
    else $error("interrupt did not vector");
  boot_fetch_a: assert property ($rose(core_run) |-> fetch_pc == 16'h0000 && pm_addr == 12'h000)
    else $error("boot start address wrong");
  opt_fetch_a: assert property (!core_run |-> pm_addr == 12'h01f)
    else $error("option address not shown during boot");
  page_join_a: assert property (core_run && ce && (goto_req || call_req) && !irq_take
    && !return_req |=> fetch_pc[10:0] == $past(branch_target))
    else $error("branch field not taken");
  ret_restore_a: assert property (core_run && ce && call_req && !irq_take
    && !return_req ##1 ce && return_req && !irq_take |=> fetch_pc == $past(fetch_pc, 2))
    else $error("return did not restore caller");
  step_one_a: assert property (core_run && ce && fetch_step && !ld
    |=> fetch_pc == $past(fetch_pc) + 16'h0001)
    else $error("step did not advance by one");
  addr_follow_a: assert property (core_run |-> pm_addr == fetch_pc[11:0])
    else $error("fetch address off counter");
  range_flag_a: assert property (core_run && $stable(fetch_pc)
    |-> pc_out_of_range == (fetch_pc > 16'h0fff))
    else $error("range flag wrong");
  ready_pulse_a: assert property (psel && !penable && ce |=> pready ##1 !pready)
    else $error("ready not a single pulse");
  hidden_byte_a: assert property (psel && !penable && ce && paddr > 8'h10 |=> pslverr)
    else $error("unmapped access not refused");
endmodule : pcp_program_counter_asserts

bind pcp_program_counter pcp_program_counter_asserts u_chk (.mclk, .rst_n, .ce, .psel,
  .penable, .pwrite, .paddr, .pready, .pslverr, .fetch_step, .call_req, .goto_req,
  .return_req, .irq_take, .branch_target, .pm_addr, .fetch_pc, .core_run, .pc_out_of_range);

`default_nettype wire

// ---- sim/pcp_prog_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Program memory stand-in with a one-cycle registered read.
module pcp_prog_mem_model (
  // Clock.
  input wire logic        mclk,
  // Fetch port.
  input wire logic [11:0] pm_addr,
  input wire logic [13:0] opt_word,
  output logic     [13:0] pm_rdata
);
  // Other words hold an address pattern so stale data never looks like the option.
  always_ff @(posedge mclk) begin
    if (pm_addr == 12'h01f) begin
      pm_rdata <= opt_word;
    end else begin
      pm_rdata <= {2'b10, pm_addr ^ 12'ha5c};
    end
  end
endmodule : pcp_prog_mem_model

`default_nettype wire

// ---- sim/test_pcp_program_counter.sv ----
`timescale 1ns/1ps
`default_nettype none

// Drives the paging block through boot, bus and branch traffic.
module test_pcp_program_counter;
  import pcp_pkg::*;
  logic        mclk = 0, rst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, core_run, pc_out_of_range, low_voltage_reset_on;
  logic        fetch_step = 0, call_req = 0, goto_req = 0, return_req = 0, irq_take = 0;
  logic [10:0] branch_target = 11'h000;
  logic [11:0] pm_addr;
  logic [13:0] pm_rdata, opt = 14'h3fff;
  logic [15:0] fetch_pc;
  pcp_level_e  lvr_level;
  pcp_osc_e    osc_select;
  int          fail_count = 0, total_checks = 0;
  // Option words; enabled rows carry a valid level code.
  logic [13:0] o_t[7] = '{14'h3fff, 14'h00c0, 14'h3e73, 14'h0044, 14'h01c6, 14'h01f8, 14'h3ffb};
  logic        en_t[7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  pcp_level_e  lv_t[7] = '{PCP_LVL_NONE, PCP_LVL_2V6, PCP_LVL_3V0, PCP_LVL_4V0, PCP_LVL_NONE,
                           PCP_LVL_NONE, PCP_LVL_NONE};
  pcp_osc_e    os_t[7] = '{PCP_OSC_XTAL, PCP_OSC_EXT_RC, PCP_OSC_RC_4M, PCP_OSC_RC_2M,
                           PCP_OSC_RC_1M, PCP_OSC_RC_8M, PCP_OSC_INVALID};

  // Clock at 10 MHz.
  always #50 mclk = ~mclk;

  pcp_program_counter dut (.mclk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fetch_step, .call_req, .goto_req, .return_req, .irq_take,
    .branch_target, .pm_addr, .pm_rdata, .fetch_pc, .core_run, .pc_out_of_range,
    .low_voltage_reset_on, .lvr_level, .osc_select);
  pcp_prog_mem_model u_mem (.mclk, .pm_addr, .opt_word(opt), .pm_rdata);

  task automatic chk(input logic ok, input string s);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask : chk

  // One bus transfer; holds the request until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 20, "no bus answer");
  endtask : apb

  // One core request for one cycle, then the counter is compared.
  task automatic ev(input logic [3:0] m, input logic [10:0] t, input logic [15:0] x);
    @(posedge mclk);
    {irq_take, return_req, call_req, goto_req} <= m;
    branch_target <= t;
    @(posedge mclk);
    {irq_take, return_req, call_req, goto_req} <= 4'h0;
    @(negedge mclk);
    chk(fetch_pc === x, "counter load wrong");
  endtask : ev

  task automatic boot(input int i);
    @(posedge mclk);
    rst_n <= 1'b0;
    opt <= o_t[i];
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk(fetch_pc === 16'h0000 && core_run === 1'b1, "boot vector");
    chk(low_voltage_reset_on === en_t[i], "reset enable");
    chk(lvr_level === lv_t[i], "reset level");
    chk(osc_select === os_t[i], "oscillator");
    apb(1'b0, 8'h08, 32'h0);
    chk(rd === {18'h0, o_t[i]}, "option word");
  endtask : boot

  task automatic t_regs;
    apb(1'b1, 8'h04, 32'h05);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd === 32'h05, "latch readback");
    apb(1'b1, 8'h00, 32'h34);
    @(negedge mclk);
    chk(fetch_pc === 16'h0534, "low byte load");
    apb(1'b0, 8'h00, 32'h0);
    chk(rd === 32'h34, "low byte read");
    apb(1'b0, 8'h14, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read");
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd === {25'h0, 1'b0, PCP_OSC_XTAL, PCP_LVL_NONE, 1'b0} && er === 1'b0, "decoded view");
    apb(1'b0, 8'h10, 32'h0);
    chk(rd === 32'h1, "status view");
  endtask : t_regs

  task automatic t_branch;
    apb(1'b1, 8'h04, 32'h0d);
    ev(4'h1, 11'h123, 16'h0923);
    ev(4'h2, 11'h7ff, 16'h0fff);
    ev(4'h8, 11'h000, 16'h0004);
    ev(4'h4, 11'h000, 16'h0fff);
    ev(4'h4, 11'h000, 16'h0923);
    ev(4'hc, 11'h000, 16'h0004);
    ev(4'h4, 11'h000, 16'h0923);
    // A call followed at once by a return brings the caller back.
    @(posedge mclk);
    call_req <= 1'b1;
    branch_target <= 11'h055;
    @(posedge mclk);
    call_req <= 1'b0;
    return_req <= 1'b1;
    @(posedge mclk);
    return_req <= 1'b0;
    @(negedge mclk);
    chk(fetch_pc === 16'h0923, "call then return");
  endtask : t_branch

  task automatic t_stack;
    int k;
    apb(1'b1, 8'h04, 32'h0);
    for (k = 1; k <= 9; k++) ev(4'h2, 11'(k), 16'(k));
    for (k = 8; k >= 1; k--) ev(4'h4, 11'h0, 16'(k));
    ev(4'h4, 11'h0, 16'h0008);
  endtask : t_stack

  // Three steps across the end of memory, then two frozen cycles.
  task automatic t_step;
    apb(1'b1, 8'h04, 32'h0f);
    apb(1'b1, 8'h00, 32'hff);
    @(posedge mclk);
    fetch_step <= 1'b1;
    repeat (3) @(posedge mclk);
    ce <= 1'b0;
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    fetch_step <= 1'b0;
    @(negedge mclk);
    chk(fetch_pc === 16'h1002 && pc_out_of_range === 1'b1, "step past end");
    apb(1'b0, 8'h10, 32'h0);
    chk(rd === 32'h3, "status past end");
  endtask : t_step

  task automatic print_verdict;
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // Main sequence: every option row boots once, core traffic after the first.
  initial begin
    for (int i = 0; i < 7; i++) begin
      boot(i);
      if (i == 0) begin
        t_regs();
        t_branch();
        t_stack();
        t_step();
      end
    end
    print_verdict();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end
endmodule : test_pcp_program_counter

`default_nettype wire
